// [pti_data_dly.sv]
// Fixed delay of every probe data channel ahead of capture.
// Assumes asynchronous probe data pins; two synchroniser stages come first.
`timescale 1ns/1ns
module pti_data_dly
  import pti_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [pti_pkg::N_PROBE*pti_pkg::N_CH-1:0] din,
  output logic [pti_pkg::N_PROBE*pti_pkg::N_CH-1:0] dout
);
  import pti_pkg::*;

  localparam int W = N_PROBE * N_CH;

  // ----------------------------------------------------------------
  // Per-channel synchroniser and delay
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < W; c++) begin : g_ch
      logic s1_reg;
      logic s2_reg;
      logic [DLY_CYC-1:0] dl_reg;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          dl_reg <= '0;
        end else if (ce) begin
          s1_reg <= din[c];
          s2_reg <= s1_reg;
          // Clock and qualifier get this much head start
          // Newest sample enters at the top, oldest leaves at bit zero
          dl_reg <= DLY_CYC'({s2_reg, dl_reg} >> 1);
        end
      end
      assign dout[c] = dl_reg[0];
    end
  endgenerate

  dly_fixed_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(ce, 1) && $past(ce, 2) && $past(ce, 3) |-> dout == $past(din, 3))
    else $error("data delay not fixed");

endmodule

// [pti_pkg.sv]
// Shared constants and types of the probe identification and threshold block.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
package pti_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int SCLK_NS = 320;
  localparam int HALF_CYC = SCLK_NS / (2 * CLK_NS);
  localparam int DLY_NS = 22;
  // Least time, rounded up to whole cycles
  localparam int DLY_CYC = (DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_CYC = 2;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_PROBE = 3;
  localparam int N_CH = 8;
  localparam int ID_BITS = 8;
  localparam int HC_W = 3;
  localparam int BIT_W = 4;
  localparam int SC_W = 2;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_THR = 4'h1;
  localparam logic [3:0] IDX_STAT = 4'h1;
  localparam logic [3:0] IDX_CTRL = 4'h2;
  localparam logic [3:0] IDX_ISTAT = 4'h8;
  localparam logic [3:0] IDX_IMASK = 4'h9;
  localparam logic [3:0] IDX_ID0 = 4'hA;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_POLL_LSB = 4;
  localparam int CTRL_START_BIT = 7;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_PRES_LSB = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_PRES = 1;
  localparam int IRQ_THR = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] THR_RST = 8'h80;
  localparam logic [2:0] POLL_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  typedef enum logic [3:0] {
    SH_IDLE = 4'b0001,
    SH_HIGH = 4'b0010,
    SH_LOW = 4'b0100,
    SH_DONE = 4'b1000
  } pti_sh_state_t;

endpackage

// [pti_probe_model.sv]
// Behavioural model of the three probe connectors with serial identification.
// Assumes poll lines and shift clock come from the block; open inputs pull up.
`timescale 1ns/1ns
module pti_probe_model
  import pti_pkg::*;
#(
  parameter logic [2:0] FITTED = 3'b101,
  // Type codes are arbitrary
  parameter logic [20:0] TYPE_BITS = 21'h0a_5a3d,
  parameter logic [2:0] PRESSED = 3'b001
)
(
  input wire logic [pti_pkg::N_PROBE-1:0] poll,
  input wire logic sclk,
  output logic [pti_pkg::N_PROBE-1:0] ret
);
  import pti_pkg::*;
  logic [N_PROBE-1:0] bit_q = '0;
  int idx [N_PROBE] = '{0, 0, 0};

  function automatic logic [7:0] id_of(input int i);
    return {TYPE_BITS[i*7 +: 7], ~PRESSED[i]};
  endfunction

  // Each rise puts out the next bit, first bit is the top one
  always @(posedge sclk) begin
    logic [7:0] w;
    for (int i = 0; i < N_PROBE; i++) begin
      w = id_of(i);
      if (poll[i] && idx[i] < ID_BITS) begin
        bit_q[i] <= w[7-idx[i]];
        idx[i] <= idx[i] + 1;
      end
    end
  end

  // After the last bit the line falls back to the presence level
  always @(negedge sclk) begin
    for (int i = 0; i < N_PROBE; i++) begin
      if (idx[i] == ID_BITS) begin
        bit_q[i] <= 1'b0;
        idx[i] <= 0;
      end
    end
  end

  // Pull-up wins with no probe; a fitted probe holds low outside a read
  assign ret = ~FITTED | (FITTED & poll & bit_q);
endmodule

// [pti_sh_if.sv]
// Carrier between the register side and the shift engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface pti_sh_if;
  logic start;
  logic busy;
  logic done;
  logic sclk;
  logic [2:0] ret;
  logic [23:0] id;
  modport ctl (output start, output ret, input busy, input done, input sclk, input id);
  modport eng (input start, input ret, output busy, output done, output sclk, output id);
endinterface

// [pti_shift_eng.sv]
// Shift clock generator and serial identification capture.
// Assumes return lines arrive already synchronised to mclk.
`timescale 1ns/1ns
module pti_shift_eng
  import pti_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  pti_sh_if.eng sh
);
  import pti_pkg::*;

  pti_sh_state_t state_reg;
  logic [HC_W-1:0] half_reg;
  logic [BIT_W-1:0] bit_reg;
  logic sclk_reg;
  logic done_reg;
  logic sample;

  // ----------------------------------------------------------------
  // Pulse sequencer
  // ----------------------------------------------------------------
  assign sample = (state_reg == SH_HIGH) && (half_reg == HC_W'(HALF_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= SH_IDLE;
      half_reg <= '0;
      bit_reg <= '0;
      sclk_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= 1'b0;
      case (state_reg)
        SH_IDLE: begin
          if (sh.start) begin
            state_reg <= SH_HIGH;
            sclk_reg <= 1'b1;
            half_reg <= '0;
            bit_reg <= '0;
          end
        end
        SH_HIGH: begin
          if (sample) begin
            state_reg <= SH_LOW;
            sclk_reg <= 1'b0;
            half_reg <= '0;
          end else begin
            half_reg <= half_reg + 1'b1;
          end
        end
        SH_LOW: begin
          if (half_reg == HC_W'(HALF_CYC - 1)) begin
            half_reg <= '0;
            // Exactly eight pulses per read
            if (bit_reg == BIT_W'(ID_BITS - 1)) begin
              state_reg <= SH_DONE;
            end else begin
              bit_reg <= bit_reg + 1'b1;
              state_reg <= SH_HIGH;
              sclk_reg <= 1'b1;
            end
          end else begin
            half_reg <= half_reg + 1'b1;
          end
        end
        SH_DONE: begin
          done_reg <= 1'b1;
          state_reg <= SH_IDLE;
        end
        default: begin
          state_reg <= SH_IDLE;
          sclk_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-probe capture, first bit lands in the top bit
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < N_PROBE; p++) begin : g_id
      logic [ID_BITS-1:0] id_reg;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          id_reg <= '0;
        end else if (ce && sample) begin
          // Late in the high phase so the new bit has settled
          id_reg <= {id_reg[ID_BITS-2:0], sh.ret[p]};
        end
      end
      assign sh.id[p*ID_BITS +: ID_BITS] = id_reg;
    end
  endgenerate

  assign sh.busy = (state_reg != SH_IDLE);
  assign sh.done = done_reg;
  assign sh.sclk = sclk_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [BIT_W-1:0] rise_cnt_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n || (ce && sh.start && state_reg == SH_IDLE)) begin
      rise_cnt_reg <= '0;
    end else if (ce && sclk_reg && !$past(sclk_reg)) begin
      rise_cnt_reg <= rise_cnt_reg + 1'b1;
    end
  end

  pulse_count_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    $rose(done_reg) |-> rise_cnt_reg == 4'd8)
    else $error("shift pulse count wrong");

  high_width_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    $rose(sclk_reg) |-> sclk_reg [*4] ##1 !sclk_reg)
    else $error("shift clock high phase wrong");

endmodule

// [pti_top.sv]
// Probe presence, serial identification and threshold loading, Wishbone slave.
// Assumes classic Wishbone on mclk; probe pins are asynchronous to mclk.
//
// Contract
// - Each probe reports an eight-bit identity, one bit at a time.
// - Control bits four to six drive the three probe poll lines high.
// - Control bits zero to two are ignored.
// - Shift clock toggles only while polling; each rise advances a probe bit.
// - All connector return bits readable in one status port.
// - Return line reads high without probe; low means probe present.
// - One read produces exactly eight shift clock pulses.
// - Threshold word goes out with a strobe pulse.
// - Threshold code is offset binary; mid code means zero volts.
// - Probe data channels are delayed a fixed time before capture.
// - Converter takes the word as the strobe falls; data held stable.
// - Threshold strobe comes from a host write to port one.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
module pti_top
  import pti_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic [pti_pkg::N_PROBE-1:0] poll_o,
  output logic sclk_o,
  input wire logic [pti_pkg::N_PROBE-1:0] ret_i,
  output logic [7:0] thr_data_o,
  output logic thr_strobe_o,
  input wire logic [pti_pkg::N_PROBE*pti_pkg::N_CH-1:0] pdata_i,
  output logic [pti_pkg::N_PROBE*pti_pkg::N_CH-1:0] pdata_o
);
  import pti_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pti_sh_if sh ();

  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [2:0] poll_reg;
  logic start_reg;
  logic [7:0] thr_reg;
  logic thr_stb_reg;
  logic [SC_W-1:0] stb_cnt_reg;
  logic [IRQ_W-1:0] istat_reg;
  logic [IRQ_W-1:0] istat_next;
  logic [IRQ_W-1:0] imask_reg;
  logic irq_reg;
  logic [2:0] ret_s1_reg;
  logic [2:0] ret_s2_reg;
  logic [2:0] ret_prev_reg;

  logic wb_req;
  logic wr;
  logic rd;
  logic hit;
  logic [3:0] idx;
  logic wr_ctrl;
  logic wr_thr;
  logic wr_istat;
  logic wr_imask;
  logic [IRQ_W-1:0] ev;
  logic [31:0] rmux;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign idx = wb_adr_i[5:2];
  assign hit = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00);
  // Registers are byte wide; only lane zero carries a write
  assign wr = wb_req && wb_we_i && wb_sel_i[0] && hit;
  assign rd = wb_req && !wb_we_i;
  // Poll bits frozen during a read, so polling outlasts the pulses
  assign wr_ctrl = wr && (idx == IDX_CTRL) && !sh.busy;
  assign wr_thr = wr && (idx == IDX_THR);
  assign wr_istat = wr && (idx == IDX_ISTAT);
  assign wr_imask = wr && (idx == IDX_IMASK);

  // ----------------------------------------------------------------
  // Bus answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= wb_req;
    end
  end

  always_comb begin
    rmux = 32'h0000_0000;
    if (hit) begin
      case (idx)
        IDX_STAT: begin
          // One bit per connector, plus presence and busy
          rmux[2:0] = ret_s2_reg;
          rmux[STAT_BUSY_BIT] = sh.busy;
          rmux[STAT_PRES_LSB +: N_PROBE] = ~ret_s2_reg;
        end
        IDX_CTRL: begin
          // Low three bits always read zero
          rmux[CTRL_POLL_LSB +: N_PROBE] = poll_reg;
        end
        IDX_ISTAT: begin
          rmux[IRQ_W-1:0] = istat_reg;
        end
        IDX_IMASK: begin
          rmux[IRQ_W-1:0] = imask_reg;
        end
        IDX_ID0: begin
          rmux[ID_BITS-1:0] = sh.id[0 +: ID_BITS];
        end
        IDX_ID0 + 4'h1: begin
          rmux[ID_BITS-1:0] = sh.id[ID_BITS +: ID_BITS];
        end
        IDX_ID0 + 4'h2: begin
          rmux[ID_BITS-1:0] = sh.id[2*ID_BITS +: ID_BITS];
        end
        default: begin
          rmux = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdat_reg <= 32'h0000_0000;
    end else if (ce) begin
      rdat_reg <= rd ? rmux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Return line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ret_s1_reg <= 3'b111;
      ret_s2_reg <= 3'b111;
      ret_prev_reg <= 3'b111;
    end else if (ce) begin
      ret_s1_reg <= ret_i;
      ret_s2_reg <= ret_s1_reg;
      ret_prev_reg <= ret_s2_reg;
    end
  end

  assign sh.ret = ret_s2_reg;

  // ----------------------------------------------------------------
  // Probe control port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      poll_reg <= POLL_RST;
    end else if (ce && wr_ctrl) begin
      // Only bits four to six are stored
      poll_reg <= wb_dat_i[CTRL_POLL_LSB +: N_PROBE];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
    end else if (ce) begin
      // A read needs at least one poll line high
      start_reg <= wr_ctrl && wb_dat_i[CTRL_START_BIT]
                   && (wb_dat_i[CTRL_POLL_LSB +: N_PROBE] != 3'b000);
    end
  end

  assign sh.start = start_reg;

  pti_shift_eng u_eng (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .sh(sh)
  );

  // ----------------------------------------------------------------
  // Threshold converter load
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      thr_reg <= THR_RST;
      thr_stb_reg <= 1'b0;
      stb_cnt_reg <= '0;
    end else if (ce) begin
      if (wr_thr && !thr_stb_reg) begin
        // Word and strobe rise together
        thr_reg <= wb_dat_i[7:0];
        thr_stb_reg <= 1'b1;
        stb_cnt_reg <= '0;
      end else if (thr_stb_reg) begin
        if (stb_cnt_reg == SC_W'(STB_CYC - 1)) begin
          // Word stays put across the falling edge
          thr_stb_reg <= 1'b0;
        end else begin
          stb_cnt_reg <= stb_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[IRQ_DONE] = sh.done;
    // Presence only judged while no read is shifting
    ev[IRQ_PRES] = !sh.busy && !start_reg && (ret_s2_reg != ret_prev_reg);
    ev[IRQ_THR] = thr_stb_reg && (stb_cnt_reg == SC_W'(STB_CYC - 1));
    istat_next = istat_reg;
    if (wr_istat) begin
      istat_next = istat_reg & ~wb_dat_i[IRQ_W-1:0];
    end
    // Event beats a clear in the same cycle
    istat_next = istat_next | ev;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      istat_reg <= IRQ_RST;
      imask_reg <= IRQ_RST;
      irq_reg <= 1'b0;
    end else if (ce) begin
      istat_reg <= istat_next;
      if (wr_imask) begin
        imask_reg <= wb_dat_i[IRQ_W-1:0];
      end
      irq_reg <= |(istat_reg & imask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Probe data delay
  // ----------------------------------------------------------------
  pti_data_dly u_dly (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .din(pdata_i),
    .dout(pdata_o)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign irq_o = irq_reg;
  assign poll_o = poll_reg;
  assign sclk_o = sh.sclk;
  assign thr_data_o = thr_reg;
  assign thr_strobe_o = thr_stb_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n || !ce);

  poll_follow_a: assert property (
    wr_ctrl |=> poll_o == $past(wb_dat_i[6:4]))
    else $error("poll lines do not follow control write");

  ctrl_unused_a: assert property (
    rd && hit && idx == IDX_CTRL |=> wb_dat_o[2:0] == 3'b000 && wb_ack_o)
    else $error("unused control bits not zero");

  sclk_poll_a: assert property (
    sclk_o |-> poll_o != 3'b000)
    else $error("shift clock without poll");

  stat_map_a: assert property (
    rd && hit && idx == IDX_STAT |=> wb_dat_o[2:0] == $past(ret_s2_reg)
      && wb_dat_o[6:4] == ~$past(ret_s2_reg))
    else $error("status port mismatch");

  thr_load_a: assert property (
    wr_thr && !thr_strobe_o |=> thr_strobe_o && thr_data_o == $past(wb_dat_i[7:0]))
    else $error("threshold load wrong");

  thr_hold_a: assert property (
    $rose(thr_strobe_o) |-> thr_strobe_o [*2] ##1 (!thr_strobe_o && $stable(thr_data_o)))
    else $error("threshold strobe shape wrong");

  thr_reset_a: assert property (
    $rose(rst_n) |-> thr_data_o == 8'h80)
    else $error("threshold not mid code after reset");

  irq_sticky_a: assert property (
    sh.done |=> istat_reg[IRQ_DONE] ##1 (irq_o || !$past(imask_reg[IRQ_DONE]) || $past(wr_istat)))
    else $error("done event lost");

endmodule

// [pti_top_tb_top.sv]
// Self-checking bench of the probe identification and threshold block.
// Assumes probe A and C fitted, B empty; A has its identify button held.
`timescale 1ns/1ns
module pti_top_tb_top;
  import pti_pkg::*;
  localparam logic [20:0] TYPES = 21'h0a_5a3d;
  localparam logic [2:0] PRESS = 3'b001;
  logic mclk = 0;
  logic rst_n = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [N_PROBE-1:0] poll_o;
  logic sclk_o;
  logic [N_PROBE-1:0] ret_i;
  logic [7:0] thr_data_o;
  logic thr_strobe_o;
  logic [N_PROBE*N_CH-1:0] pdata_i = '0;
  logic [N_PROBE*N_CH-1:0] pdata_o;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int n_sclk = 0;
  int n_stb = 0;
  int stb_run = 0;
  int stb_last = 0;
  logic [7:0] stb_data = '0;
  logic stb_q = 0;
  logic sclk_q = 0;

  pti_top pti_top_inst (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .poll_o(poll_o), .sclk_o(sclk_o), .ret_i(ret_i), .thr_data_o(thr_data_o),
    .thr_strobe_o(thr_strobe_o), .pdata_i(pdata_i), .pdata_o(pdata_o));
  pti_probe_model #(.FITTED(3'b101), .TYPE_BITS(TYPES), .PRESSED(PRESS))
    pti_probe_model_inst (.poll(poll_o), .sclk(sclk_o), .ret(ret_i));

  // ----------------------------------------------------------------
  // Clock, monitors, timeout
  // ----------------------------------------------------------------
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    sclk_q <= sclk_o;
    if (sclk_o === 1'b1 && sclk_q === 1'b0) n_sclk <= n_sclk + 1;
    stb_q <= thr_strobe_o;
    if (thr_strobe_o === 1'b1) stb_run <= stb_run + 1;
    else if (stb_q === 1'b1) begin
      stb_last <= stb_run;
      stb_data <= thr_data_o;
      stb_run <= 0;
      n_stb <= n_stb + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= d;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_cycle(a, 1'b0, 32'h0000_0000, q);
    chk(what, e, q);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("thr reset", 32'h0000_0080, thr_data_o);
    chk("poll reset", 32'h0000_0000, poll_o);
    chk("sclk idle", 32'h0000_0000, sclk_o);
    rd_chk("status", 8'h04, 32'h0000_0052);
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    wr(8'h08, 32'h0000_0077);
    chk("poll on", 32'h0000_0007, poll_o);
    rd_chk("ctrl rd", 8'h08, 32'h0000_0070);
    wr(8'h08, 32'h0000_0007);
    chk("poll off", 32'h0000_0000, poll_o);
    chk("no strobe", 32'h0000_0000, n_stb);
    $display("test ctrl done");
  endtask
  task automatic t_thr;
    logic [7:0] v [3] = '{8'hff, 8'h00, 8'h80};
    for (int k = 0; k < 3; k++) begin
      wr(8'h04, {24'h00_0000, v[k]});
      repeat (4) @(posedge mclk);
      #1;
      chk("thr word", v[k], thr_data_o);
      chk("stb pulses", k + 1, n_stb);
      chk("stb width", STB_CYC, stb_last);
      chk("word at fall", v[k], stb_data);
    end
    $display("test threshold done");
  endtask
  task automatic t_read;
    logic [31:0] q;
    int n;
    wr(8'h20, 32'h0000_0007);
    wr(8'h24, 32'h0000_0001);
    n_sclk = 0;
    wr(8'h08, 32'h0000_00f0);
    n = 0;
    do begin
      wb_cycle(8'h04, 1'b0, 32'h0000_0000, q);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 100 || n_sclk == 0 && n < 100);
    repeat (12) @(posedge mclk);
    chk("sclk pulses", 32'd8, n_sclk);
    rd_chk("id a", 8'h28, {24'h0, TYPES[6:0], ~PRESS[0]});
    rd_chk("id b", 8'h2c, 32'h0000_00ff);
    rd_chk("id c", 8'h30, {24'h0, TYPES[20:14], ~PRESS[2]});
    chk("irq on", 32'h0000_0001, irq_o);
    rd_chk("istat", 8'h20, 32'h0000_0001);
    wr(8'h24, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk("irq masked", 32'h0000_0000, irq_o);
    wr(8'h20, 32'h0000_0001);
    rd_chk("istat clr", 8'h20, 32'h0000_0000);
    rd_chk("unmapped", 8'h3c, 32'h0000_0000);
    rd_chk("high adr", 8'h44, 32'h0000_0000);
    $display("test read done");
  endtask
  task automatic t_delay;
    @(posedge mclk);
    pdata_i <= 24'h12_3456;
    repeat (5) @(posedge mclk);
    pdata_i <= 24'hab_cdef;
    repeat (2) @(posedge mclk);
    #1;
    chk("dly early", 32'h0012_3456, pdata_o);
    @(posedge mclk);
    #1;
    chk("dly exact", 32'h00ab_cdef, pdata_o);
    $display("test delay done");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_ctrl();
    t_thr();
    t_read();
    t_delay();
    stop_test();
  end
endmodule
